// >>> include/spiop_pkg.sv
/*
 package for the shared parallel io port: widths, reset values,
 implemented-bit mask and the carrier structs.
 assumes nothing of its surroundings.
*/
package spiop_pkg;
	localparam int SPIOP_W = 16;
	typedef logic [SPIOP_W-1:0] spiop_word_t;
	// bits that exist on this port; others read as zero
	localparam spiop_word_t SPIOP_IMPL_MASK = 16'h003f;
	// all pins come up as inputs
	localparam spiop_word_t SPIOP_DIR_RST = 16'hffff;
	localparam spiop_word_t SPIOP_LAT_RST = 16'h0000;
	localparam spiop_word_t SPIOP_PIN_RST = 16'h0000;

	typedef enum logic [1:0] {
		SPIOP_SEL_DIR,
		SPIOP_SEL_LAT,
		SPIOP_SEL_PIN,
		SPIOP_SEL_NONE
	} spiop_sel_e;

	// cpu access to the port
	typedef struct packed {
		logic wr;
		logic rd;
		spiop_sel_e sel;
		spiop_word_t wdata;
	} spiop_req_s;

	// peripheral side of the output multiplexers
	typedef struct packed {
		spiop_word_t enable;
		spiop_word_t drive;
		spiop_word_t data;
	} spiop_periph_s;

	// pad cell controls
	typedef struct packed {
		spiop_word_t out;
		spiop_word_t oe;
	} spiop_pad_s;
endpackage

// >>> verilog/spiop_pad_mux.sv
/*
 per-pin output multiplexer pair choosing peripheral or port ownership.
 assumes peripheral enable and drive are synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module spiop_pad_mux
	import spiop_pkg::*;
(
	// port side
	input wire spiop_word_t port_data,
	input wire spiop_word_t port_oe,
	// peripheral side
	input wire spiop_periph_s periph,
	// pad side
	output spiop_pad_s pad_next
);
	wire spiop_word_t periph_owns;

	assign periph_owns = periph.enable & periph.drive & SPIOP_IMPL_MASK;
	assign pad_next.out = (periph_owns & periph.data) |
		(~periph_owns & port_data);
	assign pad_next.oe = (periph_owns & periph.drive) |
		(~periph_owns & port_oe);
endmodule
`default_nettype wire

// >>> verilog/spiop_port.sv
/*
 shared parallel io port: direction, output latch and pin-state paths,
 pad ownership by peripherals and analog-pin effects on reads.
 assumes a synchronous cpu access port and pad inputs synchronous to
 clk_sys; pad wire resolution is done outside.
 accesses may come back to back; a read in the same cycle as a write
 returns the value from before that write.
*/
`timescale 1ns/100ps
`default_nettype none
module spiop_port
	import spiop_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// cpu access
	input wire spiop_req_s req,
	output spiop_word_t rdata,
	output logic rvalid,
	// configuration
	input wire spiop_word_t analog_pin_config,
	// peripherals
	input wire spiop_periph_s periph,
	// pads
	input wire spiop_word_t pad_in,
	output spiop_pad_s pad,
	// converter feed
	output spiop_word_t adc_level,
	output spiop_word_t adc_connect
);
	spiop_word_t pin_direction_reg;
	spiop_word_t output_latch_reg;
	spiop_word_t pin_sync;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// keeps only the bits that exist on this port
	function automatic spiop_word_t impl_only(input spiop_word_t word);
		return word & SPIOP_IMPL_MASK;
	endfunction

	// write strobe aimed at one target
	function automatic logic wr_hit(input spiop_req_s r,
		input spiop_sel_e s);
		return r.wr && r.sel == s;
	endfunction

	// read strobe aimed at one target
	function automatic logic rd_hit(input spiop_req_s r,
		input spiop_sel_e s);
		return r.rd && r.sel == s;
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic wr_dir;
	wire logic wr_lat;
	wire spiop_word_t next_dir;
	wire spiop_word_t next_lat;
	wire spiop_word_t pin_state_reg;
	wire spiop_word_t next_rdata;
	wire spiop_word_t port_oe;
	wire spiop_word_t analog_in;
	wire spiop_pad_s next_pad;
	wire logic wr_lat_direct;
	wire logic wr_pin;
	wire logic rd_dir;
	wire logic rd_lat;
	wire logic rd_pin;
	wire spiop_word_t dir_view;
	wire spiop_word_t next_adc_connect;
	wire spiop_word_t next_adc_level;

	assign wr_dir = wr_hit(req, SPIOP_SEL_DIR);
	assign wr_lat_direct = wr_hit(req, SPIOP_SEL_LAT);
	assign wr_pin = wr_hit(req, SPIOP_SEL_PIN);
	assign wr_lat = wr_lat_direct || wr_pin;
	assign rd_dir = rd_hit(req, SPIOP_SEL_DIR);
	assign rd_lat = rd_hit(req, SPIOP_SEL_LAT);
	assign rd_pin = rd_hit(req, SPIOP_SEL_PIN);

	assign next_dir = wr_dir ? impl_only(req.wdata) : pin_direction_reg;
	assign next_lat = wr_lat ? impl_only(req.wdata) : output_latch_reg;

	assign port_oe = impl_only(~pin_direction_reg);

	// analog input only when direction is input
	assign analog_in = impl_only(analog_pin_config & pin_direction_reg);

	assign pin_state_reg = impl_only(pin_sync & ~analog_in);
	assign dir_view = impl_only(pin_direction_reg);

	assign next_rdata = !req.rd ? rdata :
		rd_dir ? dir_view :
		rd_lat ? output_latch_reg :
		rd_pin ? pin_state_reg : '0;

	// ------------------------------------------------------------
	// output multiplexers
	// ------------------------------------------------------------
	// idle peripheral leaves port
	spiop_pad_mux u_mux (
		.port_data(output_latch_reg),
		.port_oe(port_oe),
		.periph(periph),
		.pad_next(next_pad)
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset to inputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_direction_reg <= SPIOP_DIR_RST & SPIOP_IMPL_MASK;
		end else begin
			pin_direction_reg <= next_dir;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			output_latch_reg <= SPIOP_LAT_RST;
		end else begin
			output_latch_reg <= next_lat;
		end
	end

	// ------------------------------------------------------------
	// pin-state path
	// ------------------------------------------------------------
	// one stage only: pads are taken as synchronous to clk_sys
	// pad input register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync <= SPIOP_PIN_RST;
		end else begin
			pin_sync <= pad_in;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// rdata holds the last answer between reads
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pad <= '0;
		end else begin
			pad <= next_pad;
		end
	end

	// ------------------------------------------------------------
	// converter feed
	// ------------------------------------------------------------
	// only analog pins, either direction
	assign next_adc_connect = impl_only(analog_pin_config &
		(pin_direction_reg | port_oe));
	// output pin shows its driven level
	assign next_adc_level = impl_only(pad_in & analog_pin_config);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adc_connect <= '0;
			adc_level <= '0;
		end else begin
			adc_connect <= next_adc_connect;
			adc_level <= next_adc_level;
		end
	end
endmodule
`default_nettype wire

// >>> tb/spiop_props.sv
/* spiop_port port checker
 bound into every spiop_port */
`timescale 1ns/100ps
`default_nettype none
module spiop_props
	import spiop_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire spiop_req_s req,
	input wire spiop_word_t rdata,
	input wire logic rvalid,
	input wire spiop_word_t analog_pin_config,
	input wire spiop_periph_s periph,
	input wire spiop_word_t pad_in,
	input wire spiop_pad_s pad,
	input wire spiop_word_t adc_level,
	input wire spiop_word_t adc_connect
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire spiop_word_t own = periph.enable & periph.drive & SPIOP_IMPL_MASK;
	sequence pin_rd_s;
		req.rd && req.sel == SPIOP_SEL_PIN && analog_pin_config == '0 &&
		$past(rst_n);
	endsequence
	rd_answer_a:
		assert property (req.rd |=> rvalid) else $error("no rvalid");
	rd_cause_a:
		assert property (rvalid |-> $past(req.rd)) else $error("stray rvalid");
	none_read_a:
		assert property (req.rd && req.sel == SPIOP_SEL_NONE |=> rdata == '0)
		else $error("none read not zero");
	own_oe_a:
		assert property (own != '0 |=> (pad.oe & $past(own)) == $past(own))
		else $error("port kept driver");
	own_data_a:
		assert property (own != '0 |=>
		((pad.out ^ $past(periph.data)) & $past(own)) == '0)
		else $error("peripheral data lost");
	unimpl_zero_a:
		assert property (((rdata | pad.oe | pad.out | adc_connect) &
		~SPIOP_IMPL_MASK) == '0) else $error("missing bit not zero");
	adc_route_a:
		assert property (1'b1 |=>
		adc_connect == ($past(analog_pin_config) & SPIOP_IMPL_MASK))
		else $error("converter routing wrong");
	adc_level_a:
		assert property (1'b1 |=> adc_level ==
		($past(pad_in) & $past(analog_pin_config) & SPIOP_IMPL_MASK))
		else $error("converter level wrong");
	pin_read_a:
		assert property (pin_rd_s |=>
		rdata == ($past(pad_in, 2) & SPIOP_IMPL_MASK))
		else $error("pin read wrong");
endmodule
bind spiop_port spiop_props u_props (.clk_sys, .rst_n, .req, .rdata,
	.rvalid, .analog_pin_config, .periph, .pad_in, .pad, .adc_level,
	.adc_connect);
`default_nettype wire

// >>> tb/spiop_pad_model.sv
/* pad model: each pin shows its own drive, else the board level
 assumes pad comes straight from spiop_port */
`timescale 1ns/100ps
`default_nettype none
module spiop_pad_model
	import spiop_pkg::*;
(
	input wire spiop_pad_s pad,
	input wire spiop_word_t board,
	output spiop_word_t pad_in
);
	assign pad_in = (pad.oe & pad.out) | (~pad.oe & board);
endmodule
`default_nettype wire

// >>> tb/spiop_port_tb_top.sv
/* bench for spiop_port with the pad model
 assumes spiop_pkg compiled first */
`timescale 1ns/100ps
`default_nettype none
module spiop_port_tb_top;
	import spiop_pkg::*;
	typedef struct packed {
		spiop_sel_e ws;
		spiop_word_t wd;
		spiop_sel_e rs;
		spiop_word_t ex;
	} spiop_row_s;
	logic clk_sys, rst_n, rvalid;
	spiop_req_s req;
	spiop_periph_s periph;
	spiop_pad_s pad;
	spiop_word_t analog_pin_config, pad_in, rdata, board, adc_level, adc_connect;
	int err_total, comparisons;
	spiop_row_s rows [5] = '{
		'{SPIOP_SEL_DIR, 16'h0000, SPIOP_SEL_DIR, 16'h0000},
		'{SPIOP_SEL_LAT, 16'hffff, SPIOP_SEL_LAT, 16'h003f},
		'{SPIOP_SEL_PIN, 16'h0015, SPIOP_SEL_LAT, 16'h0015},
		'{SPIOP_SEL_NONE, 16'h002a, SPIOP_SEL_PIN, 16'h0015},
		'{SPIOP_SEL_DIR, 16'h0002, SPIOP_SEL_NONE, 16'h0000}};
	spiop_port DUT (.clk_sys, .rst_n, .req, .rdata, .rvalid,
		.analog_pin_config, .periph, .pad_in, .pad, .adc_level, .adc_connect);
	spiop_pad_model u_pads (.pad, .board, .pad_in);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic op(input spiop_sel_e s, input logic w, input spiop_word_t d);
		@(negedge clk_sys);
		req <= '{w, !w, s, d};
		@(negedge clk_sys);
		req <= '0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic chk(input spiop_word_t g, input spiop_word_t e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d of %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#5000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		{rst_n, req, analog_pin_config, periph} = '0;
		board = 16'hffff;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			op(rows[i].ws, 1'b1, rows[i].wd);
			op(rows[i].rs, 1'b0, '0);
			chk(rdata, rows[i].ex);
		end
		op(SPIOP_SEL_PIN, 1'b0, '0);
		chk(rdata, 16'h0017);
		analog_pin_config = 16'h0002;
		op(SPIOP_SEL_PIN, 1'b0, '0);
		chk(rdata, 16'h0015);
		periph = '{16'h0001, 16'h0001, 16'h0000};
		@(negedge clk_sys);
		op(SPIOP_SEL_PIN, 1'b0, '0);
		chk(rdata, 16'h0014);
		chk(pad.out, 16'h0014);
		periph.drive = '0;
		repeat (3) @(negedge clk_sys);
		chk(pad.out, 16'h0015);
		chk(pad.oe, 16'h003d);
		analog_pin_config = 16'h000e;
		repeat (2) @(negedge clk_sys);
		chk(adc_level, 16'h0006);
		chk(adc_connect, 16'h000e);
		rst_n = 1'b0;
		@(negedge clk_sys);
		rst_n = 1'b1;
		op(SPIOP_SEL_DIR, 1'b0, '0);
		chk(rdata, 16'h003f);
		chk(pad.oe, 16'h0000);
		tally_and_finish;
	end
endmodule
`default_nettype wire
